// >>> hw/psr_top.sv
// Programmable shift register engine with a classic Wishbone register slave.
// Assumes a single 100 MHz ref_clk, active-low async reset_n, and software
// issuing one evaluation per program scan through the EVAL register.
`timescale 1ns/10ps
`include "psr_regs.svh"
module psr_top #(
    parameter bit DIR_SET_TOWARD_END = 1'b1
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output      logic [31:0] wb_dat_o,
    output      logic        wb_ack_o,
    output      logic        carry_flag,
    output      logic        error_flag,
    output      logic        busy
);
    localparam int WW = `PSR_WORD_W;
    localparam int AW = `PSR_ADDR_W;

    // Two data areas of eight words; the top address bit names the area
    logic [WW-1:0] mem_reg [`PSR_NWORDS];

    // Bus-side state
    logic [WW-1:0] bctrl_reg, bctrl_next;
    logic [WW-1:0] range_reg, range_next;
    logic [AW-1:0] maddr_reg, maddr_next;
    logic [31:0]   dat_reg, dat_next;
    logic          ack_reg, ack_next;

    // Engine state
    psr_pkg::psr_state_t state_reg, state_next;
    logic [`PSR_CMD_W-1:0] cmd_reg, cmd_next;
    logic [AW-1:0] cur_reg, cur_next;
    logic [AW-1:0] last_reg, last_next;
    logic          cin_reg, cin_next;
    logic          down_reg, down_next;
    logic          left_reg, left_next;
    logic          zero_reg, zero_next;
    logic          updcf_reg, updcf_next;
    logic          prev_reg, prev_next;
    logic          cf_reg, cf_next;
    logic          err_reg, err_next;
    logic          busy_reg, busy_next;

    // Glue
    logic                  req, hit_eval, hit_mem, ok;
    logic                  fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [`PSR_CMD_W-1:0] fifo_in_data, fifo_out_data;
    logic [WW-1:0]         sh_out;
    logic                  sh_cout;
    logic                  mem_we;
    logic [AW-1:0]         mem_wa;
    logic [WW-1:0]         mem_wd;
    logic                  sw_mem_we;
    logic [AW-1:0]         us, ue, bs, be;
    logic                  cw_dir, cw_data, cw_en, cw_rst, toward_end;

    function automatic logic [WW-1:0] merge16(input logic [WW-1:0] old,
                                              input logic [31:0]   d,
                                              input logic [3:0]    sel);
        logic [WW-1:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = d[7:0];
        end
        if (sel[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    assign req      = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign hit_eval = (wb_adr_i == `PSR_OFF_EVAL);
    assign hit_mem  = (wb_adr_i == `PSR_OFF_MEMDATA);
    // Back-pressure: a full FIFO holds off an EVAL write ack, a running engine a MEMDATA write ack
    assign ok = ~(wb_we_i & hit_eval & ~fifo_in_ready) &
                ~(wb_we_i & hit_mem & busy_reg);
    assign sw_mem_we = req & ok & wb_we_i & hit_mem & (wb_sel_i[1:0] != 2'h0);

    assign fifo_in_data = {bctrl_reg[`PSR_CW_RST:`PSR_CW_DIR], wb_dat_i[`PSR_EV_CLR:0]};

    psr_fifo #(
        .WIDTH (`PSR_CMD_W),
        .DEPTH (`PSR_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .in_data   (fifo_in_data),
        .in_valid  (req & ok & wb_we_i & hit_eval & wb_sel_i[0]),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );

    psr_shift_word u_shift (
        .word_in   (mem_reg[cur_reg]),
        .carry_in  (cin_reg),
        .to_left   (left_reg),
        .word_out  (sh_out),
        .carry_out (sh_cout)
    );

    // Bus registers
    always_comb begin
        bctrl_next = bctrl_reg;
        range_next = range_reg;
        maddr_next = maddr_reg;
        dat_next   = dat_reg;
        ack_next   = 1'b0;
        if (req && ok) begin
            ack_next = 1'b1;
            dat_next = `PSR_RST_BUS;
            if (wb_we_i) begin
                unique case (wb_adr_i)
                    `PSR_OFF_BCTRL:   bctrl_next = merge16(bctrl_reg, wb_dat_i, wb_sel_i);
                    `PSR_OFF_RANGE:   range_next = merge16(range_reg, wb_dat_i, wb_sel_i);
                    `PSR_OFF_MEMADDR: begin
                        if (wb_sel_i[0]) begin
                            maddr_next = wb_dat_i[AW-1:0];
                        end
                    end
                    default: ;
                endcase
            end else begin
                unique case (wb_adr_i)
                    `PSR_OFF_BCTRL:   dat_next[WW-1:0] = bctrl_reg;
                    `PSR_OFF_RANGE:   dat_next[WW-1:0] = range_reg;
                    `PSR_OFF_MEMADDR: dat_next[AW-1:0] = maddr_reg;
                    `PSR_OFF_MEMDATA: dat_next[WW-1:0] = mem_reg[maddr_reg];
                    `PSR_OFF_STATUS: begin
                        dat_next[`PSR_STAT_CARRY] = cf_reg;
                        dat_next[`PSR_STAT_ERROR] = err_reg;
                        dat_next[`PSR_STAT_BUSY]  = busy_reg;
                        dat_next[`PSR_STAT_PREV]  = prev_reg;
                        dat_next[`PSR_STAT_FULL]  = ~fifo_in_ready;
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bctrl_reg <= `PSR_RST_WORD;
            range_reg <= `PSR_RST_WORD;
            maddr_reg <= '0;
            dat_reg   <= `PSR_RST_BUS;
            ack_reg   <= 1'b0;
        end else begin
            bctrl_reg <= bctrl_next;
            range_reg <= range_next;
            maddr_reg <= maddr_next;
            dat_reg   <= dat_next;
            ack_reg   <= ack_next;
        end
    end

    // Engine: decode one command, then walk one word per cycle
    assign us = range_reg[`PSR_RG_USTART +: AW];
    assign ue = range_reg[`PSR_RG_UEND +: AW];
    assign bs = range_reg[`PSR_RG_BSTART +: AW];
    assign be = range_reg[`PSR_RG_BEND +: AW];
    assign cw_dir  = cmd_reg[`PSR_CMD_CW + `PSR_CW_DIR - `PSR_CW_DIR];
    assign cw_data = cmd_reg[`PSR_CMD_CW + `PSR_CW_DATA - `PSR_CW_DIR];
    assign cw_en   = cmd_reg[`PSR_CMD_CW + `PSR_CW_EN - `PSR_CW_DIR];
    assign cw_rst  = cmd_reg[`PSR_CMD_CW + `PSR_CW_RST - `PSR_CW_DIR];
    assign toward_end = (cw_dir == DIR_SET_TOWARD_END);
    assign fifo_pop = (state_reg == psr_pkg::PSR_IDLE) & fifo_out_valid;

    always_comb begin
        state_next = state_reg;
        cmd_next   = cmd_reg;
        cur_next   = cur_reg;
        last_next  = last_reg;
        cin_next   = cin_reg;
        down_next  = down_reg;
        left_next  = left_reg;
        zero_next  = zero_reg;
        updcf_next = updcf_reg;
        prev_next  = prev_reg;
        cf_next    = cf_reg;
        err_next   = err_reg;
        mem_we     = 1'b0;
        mem_wa     = cur_reg;
        mem_wd     = zero_reg ? `PSR_RST_WORD : sh_out;
        unique case (state_reg)
            psr_pkg::PSR_IDLE: begin
                if (fifo_out_valid) begin
                    cmd_next   = fifo_out_data;
                    state_next = psr_pkg::PSR_DECODE;
                end
            end
            psr_pkg::PSR_DECODE: begin
                state_next = psr_pkg::PSR_IDLE;
                updcf_next = 1'b0;
                if (!cmd_reg[`PSR_CMD_KIND]) begin
                    // Serial-in: neither carry nor error flag is touched on this path
                    prev_next = cmd_reg[`PSR_CMD_PULSE];
                    cur_next  = us;
                    last_next = ue;
                    down_next = 1'b1;
                    left_next = 1'b1;
                    cin_next  = cmd_reg[`PSR_CMD_SIN];
                    // Bad bounds are the caller's fault; they just skip the shift
                    if (us[`PSR_AREA_BIT] == ue[`PSR_AREA_BIT] && ue <= us) begin
                        if (cmd_reg[`PSR_CMD_CLR]) begin
                            zero_next  = 1'b1;
                            state_next = psr_pkg::PSR_WORK;
                        end else if (cmd_reg[`PSR_CMD_PULSE] && !prev_reg) begin
                            zero_next  = 1'b0;
                            state_next = psr_pkg::PSR_WORK;
                        end
                    end
                end else if (cmd_reg[`PSR_CMD_EXEC]) begin
                    if (bs[`PSR_AREA_BIT] != be[`PSR_AREA_BIT] || bs > be) begin
                        err_next = 1'b1;
                    end else begin
                        err_next   = 1'b0;
                        updcf_next = 1'b1;
                        left_next  = toward_end;
                        down_next  = ~toward_end;
                        cur_next   = toward_end ? bs : be;
                        last_next  = toward_end ? be : bs;
                        cin_next   = cw_data;
                        if (cw_rst) begin
                            zero_next  = 1'b1;
                            state_next = psr_pkg::PSR_WORK;
                        end else if (cw_en) begin
                            zero_next  = 1'b0;
                            state_next = psr_pkg::PSR_WORK;
                        end
                    end
                end
            end
            psr_pkg::PSR_WORK: begin
                mem_we   = 1'b1;
                cin_next = sh_cout;
                cur_next = down_reg ? cur_reg - AW'(1) : cur_reg + AW'(1);
                if (cur_reg == last_reg) begin
                    state_next = psr_pkg::PSR_IDLE;
                    if (updcf_reg) begin
                        cf_next = zero_reg ? 1'b0 : sh_cout;
                    end
                end
            end
            default: state_next = psr_pkg::PSR_IDLE;
        endcase
        if (sw_mem_we) begin
            mem_we = 1'b1;
            mem_wa = maddr_reg;
            mem_wd = merge16(mem_reg[maddr_reg], wb_dat_i, wb_sel_i);
        end
        busy_next = (state_next != psr_pkg::PSR_IDLE) | fifo_out_valid |
                    (req & ok & wb_we_i & hit_eval);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= psr_pkg::PSR_IDLE;
            cmd_reg   <= '0;
            cur_reg   <= '0;
            last_reg  <= '0;
            cin_reg   <= 1'b0;
            down_reg  <= 1'b0;
            left_reg  <= 1'b0;
            zero_reg  <= 1'b0;
            updcf_reg <= 1'b0;
            prev_reg  <= 1'b0;
            cf_reg    <= 1'b0;
            err_reg   <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cmd_reg   <= cmd_next;
            cur_reg   <= cur_next;
            last_reg  <= last_next;
            cin_reg   <= cin_next;
            down_reg  <= down_next;
            left_reg  <= left_next;
            zero_reg  <= zero_next;
            updcf_reg <= updcf_next;
            prev_reg  <= prev_next;
            cf_reg    <= cf_next;
            err_reg   <= err_next;
            busy_reg  <= busy_next;
        end
    end

    // Word store; software writes only while the engine is idle, so the ports never collide
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `PSR_NWORDS; i++) begin
                mem_reg[i] <= `PSR_RST_WORD;
            end
        end else if (mem_we) begin
            mem_reg[mem_wa] <= mem_wd;
        end
    end

    assign wb_dat_o   = dat_reg;
    assign wb_ack_o   = ack_reg;
    assign carry_flag = cf_reg;
    assign error_flag = err_reg;
    assign busy       = busy_reg;
endmodule

// >>> common/psr_regs.svh
// Register offsets, field positions and sizes of the programmable shift register.
// Assumes a classic Wishbone slave with byte addresses and one 32-bit word per register.
`ifndef PSR_REGS_SVH
`define PSR_REGS_SVH

`define PSR_OFF_BCTRL     8'h00
`define PSR_OFF_RANGE     8'h04
`define PSR_OFF_EVAL      8'h08
`define PSR_OFF_STATUS    8'h0c
`define PSR_OFF_MEMADDR   8'h10
`define PSR_OFF_MEMDATA   8'h14

`define PSR_CW_DIR        12
`define PSR_CW_DATA       13
`define PSR_CW_EN         14
`define PSR_CW_RST        15

`define PSR_EV_KIND       0
`define PSR_EV_EXEC       1
`define PSR_EV_SIN        2
`define PSR_EV_PULSE      3
`define PSR_EV_CLR        4

`define PSR_RG_USTART     0
`define PSR_RG_UEND       4
`define PSR_RG_BSTART     8
`define PSR_RG_BEND       12

`define PSR_STAT_CARRY    0
`define PSR_STAT_ERROR    1
`define PSR_STAT_BUSY     2
`define PSR_STAT_PREV     3
`define PSR_STAT_FULL     4

`define PSR_CMD_KIND      0
`define PSR_CMD_EXEC      1
`define PSR_CMD_SIN       2
`define PSR_CMD_PULSE     3
`define PSR_CMD_CLR       4
`define PSR_CMD_CW        5

`define PSR_WORD_W        16
`define PSR_ADDR_W        4
`define PSR_NWORDS        16
`define PSR_AREA_BIT      3
`define PSR_CMD_W         9
`define PSR_FIFO_DEPTH    8
`define PSR_RST_WORD      16'h0000
`define PSR_RST_BUS       32'h00000000

`endif

// >>> common/psr_pkg.sv
// Types shared by the programmable shift register files.
// Assumes psr_regs.svh supplies the numeric constants.
package psr_pkg;
    typedef enum logic [1:0] {
        PSR_IDLE,
        PSR_DECODE,
        PSR_WORK
    } psr_state_t;
endpackage

// >>> hw/psr_fifo.sv
// Command FIFO of the programmable shift register.
// Assumes one clock; push on in_valid&in_ready, pop on out_valid&out_ready.
`timescale 1ns/10ps
module psr_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output      logic             in_ready,
    output      logic [WIDTH-1:0] out_data,
    output      logic             out_valid,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_reg, wr_next;
    logic [PW-1:0]    rd_reg, rd_next;
    logic [PW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    assign in_ready  = (cnt_reg != PW'(0) + (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        wr_next  = wr_reg;
        rd_next  = rd_reg;
        cnt_next = cnt_reg;
        if (push) begin
            wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + PW'(1);
        end
        if (pop) begin
            rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + PW'(1);
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + (PW+1)'(1);
        end else if (pop && !push) begin
            cnt_next = cnt_reg - (PW+1)'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage needs no reset: out_valid guards every read
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
endmodule

// >>> hw/psr_shift_word.sv
// One-place shift of a 16-bit word with a bit entering and a bit leaving.
// Purely combinational; the caller chains words through carry_in/carry_out.
`timescale 1ns/10ps
`include "psr_regs.svh"
module psr_shift_word (
    input  wire logic [`PSR_WORD_W-1:0] word_in,
    input  wire logic                   carry_in,
    input  wire logic                   to_left,
    output      logic [`PSR_WORD_W-1:0] word_out,
    output      logic                   carry_out
);
    assign carry_out = to_left ? word_in[`PSR_WORD_W-1] : word_in[0];

    for (genvar i = 0; i < `PSR_WORD_W; i++) begin : g_bit
        if (i == 0) begin : g_lo
            assign word_out[i] = to_left ? carry_in : word_in[i+1];
        end else if (i == `PSR_WORD_W - 1) begin : g_hi
            assign word_out[i] = to_left ? word_in[i-1] : carry_in;
        end else begin : g_mid
            assign word_out[i] = to_left ? word_in[i-1] : word_in[i+1];
        end
    end
endmodule

// >>> dv/psr_top_chk.sv
// Port checker for psr_top: bus answer shape and flag movement.
// Assumes classic Wishbone masters that hold the request through the ack cycle.
`timescale 1ns/10ps
`include "psr_regs.svh"
module psr_top_chk (
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        carry_flag,
    input wire logic        error_flag,
    input wire logic        busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic ev_wr;
    logic status_rd;
    assign ev_wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == `PSR_OFF_EVAL;
    assign status_rd = wb_ack_o && !wb_we_i && wb_adr_i == `PSR_OFF_STATUS;
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held beyond one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_carry_quiet: assert property ($changed(carry_flag) |-> $past(busy))
        else $error("carry moved while idle");
    a_error_quiet: assert property ($changed(error_flag) |-> $past(busy))
        else $error("error moved while idle");
    a_eval_busy: assert property (ev_wr |-> busy)
        else $error("queued scan not shown as busy");
    a_status_flags: assert property (status_rd && !$past(busy) |->
        wb_dat_o[2:0] == {1'h0, error_flag, carry_flag})
        else $error("status flags differ from pins");
    a_rd_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0)
        else $error("upper read bits not zero");
    a_wr_quiet: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
        else $error("read data driven on write");
    a_eval_rd_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `PSR_OFF_EVAL
        |-> wb_dat_o == 32'h0)
        else $error("scan register read not zero");
    a_busy_ends: assert property ($rose(busy) |-> ##[1:1000] !busy)
        else $error("engine never went idle");
    c_eval: cover property (ev_wr);
    c_carry: cover property ($fell(busy) && carry_flag);
    c_error: cover property ($rose(error_flag));
endmodule

bind psr_top psr_top_chk u_chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .carry_flag(carry_flag),
    .error_flag(error_flag), .busy(busy));

// >>> dv/psr_wb_host.sv
// Bus host standing in for the program that issues one scan per access.
// Assumes every access is answered by a one-cycle ack.
`timescale 1ns/10ps
module psr_wb_host (
    input  wire logic        ref_clk,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    output      logic        wb_cyc_i,
    output      logic        wb_stb_i,
    output      logic        wb_we_i,
    output      logic [7:0]  wb_adr_i,
    output      logic [3:0]  wb_sel_i,
    output      logic [31:0] wb_dat_i
);
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    end
    // Serial-in bounds stay in one area with the end word not above the start
    function automatic logic [3:0] ser_end(input logic [3:0] s, input int unsigned r);
        return {s[3], 3'(r % (s[2:0] + 1))};
    endfunction
    // Data lines flip after release so a stale value never passes as fresh
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge ref_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        do @(posedge ref_clk); while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_dat_i <= ~d;
    endtask
endmodule

// >>> dv/test_programmable_shift_register.sv
// Self-checking bench for psr_top: random scans of both register kinds.
// Assumes psr_wb_host as bus master and the map in psr_regs.svh.
`timescale 1ns/10ps
`include "psr_regs.svh"
module test_programmable_shift_register;
    logic        ref_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic        wb_ack_o, carry_flag, error_flag, busy, prev, carry_exp, error_exp;
    logic [15:0] m [16];
    logic [15:0] cw;
    logic [4:0]  ev;
    int          num_errors, samples_checked, us, ue, bs, be;

    psr_top u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .carry_flag(carry_flag), .error_flag(error_flag), .busy(busy));
    psr_wb_host u_host (.ref_clk(ref_clk), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i));

    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (30000) @(posedge ref_clk);
        num_errors++;
        end_of_test();
    end

    task automatic end_of_test();
        if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        u_host.xfer(1'h1, a, d, t);
    endtask
    task automatic rd(input logic [7:0] a);
        u_host.xfer(1'h0, a, 32'h0, q);
    endtask

    // Reference behaviour of one scan, applied in queue order
    function automatic void model_eval(input logic [4:0] e);
        logic c;
        logic n;
        c = e[0] ? cw[13] : e[2];
        if (!e[0]) begin
            for (int a = us; a >= ue; a--) begin
                if (e[4]) m[a] = 16'h0;
                else if (e[3] && !prev) begin
                    n = m[a][15];
                    m[a] = {m[a][14:0], c};
                    c = n;
                end
            end
            prev = e[3];
        end else if (e[1]) begin
            error_exp = (bs / 8 != be / 8) || bs > be;
            if (!error_exp && cw[15]) begin
                for (int a = bs; a <= be; a++) m[a] = 16'h0;
                carry_exp = 1'h0;
            end else if (!error_exp && cw[14] && cw[12]) begin
                for (int a = bs; a <= be; a++) begin
                    n = m[a][15];
                    m[a] = {m[a][14:0], c};
                    c = n;
                end
                carry_exp = c;
            end else if (!error_exp && cw[14]) begin
                for (int a = be; a >= bs; a--) begin
                    n = m[a][0];
                    m[a] = {c, m[a][15:1]};
                    c = n;
                end
                carry_exp = c;
            end
        end
    endfunction

    task automatic compare();
        int k;
        k = 0;
        do begin
            rd(`PSR_OFF_STATUS);
            k++;
        end while (q[2] !== 1'h0 && k < 300);
        chk("status", q, {27'h0, 1'h0, prev, 1'h0, error_exp, carry_exp});
        chk("carry_pin", {31'h0, carry_flag}, {31'h0, carry_exp});
        chk("error_pin", {31'h0, error_flag}, {31'h0, error_exp});
        for (int a = 0; a < `PSR_NWORDS; a++) begin
            wr(`PSR_OFF_MEMADDR, 32'(a));
            rd(`PSR_OFF_MEMDATA);
            chk("word", q, {16'h0, m[a]});
        end
    endtask

    initial begin
        reset_n = 1'h0;
        num_errors = 0;
        samples_checked = 0;
        {prev, carry_exp, error_exp, cw, us, ue, bs, be} = '0;
        foreach (m[a]) m[a] = 16'h0;
        q = $urandom(32'h2630);
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'h1;
        rd(8'h20);
        chk("unmapped", q, 32'h0);
        compare();
        for (int a = 0; a < `PSR_NWORDS; a++) begin
            m[a] = 16'($urandom);
            wr(`PSR_OFF_MEMADDR, 32'(a));
            wr(`PSR_OFF_MEMDATA, {16'h0, m[a]});
        end
        for (int b = 0; b < 12; b++) begin
            us = $urandom % 16;
            ue = (b == 1) ? us : u_host.ser_end(4'(us), $urandom);
            bs = $urandom % 16;
            be = (b % 2) ? $urandom % 16 : bs + $urandom % (8 - bs % 8);
            if (b == 2) be = bs;
            wr(`PSR_OFF_RANGE, {16'h0, 4'(be), 4'(bs), 4'(ue), 4'(us)});
            // Back-to-back scans queue up behind the engine; eight per batch never fill the eight-entry queue
            for (int i = 0; i < 8; i++) begin
                ev = 5'($urandom);
                ev[4] = ($urandom % 5 == 0);
                cw = 16'($urandom);
                cw[15] = ($urandom % 6 == 0);
                if (ev[0]) wr(`PSR_OFF_BCTRL, {16'h0, cw});
                wr(`PSR_OFF_EVAL, {27'h0, ev});
                model_eval(ev);
            end
            compare();
        end
        end_of_test();
    end
endmodule
